// ===== src/cdc_cal_ctrl.sv
// Calibration coefficient control with AXI4-Lite register access
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
// Function
// - On power-up or reset, gain register loads the factory gain from one-time store.
// - Gain replaced by full-scale gain calibration or by a host write.
// - Changed gain is volatile; reset restores the factory gain.
// - Offset calibration adjusts offset so zero-scale input gives code 0x800000.
// - Host may write offset register; one LSB is 31.25 aF.
// - Reset returns offset register to default; no factory offset.
// - Temperature degrees equal code over 2048 minus 4096.
// - Voltage mode uses internal 1.17 V reference or external one, as configured.
// - Supply monitor digitises supply voltage divided by 6.
// - Each of two offset capacitance converters takes a 6-bit setting.
module cdc_cal_ctrl
  import cdc_cal_pkg::*;
(
  input wire logic clk,                          // 100 MHz clock
  input wire logic rst,                          // async reset, active high
  input wire logic [COEF_W-1:0] otp_gain,        // factory gain from one-time store
  input wire logic [ADDR_W-1:0] s_axi_awaddr,    // write address
  input wire logic s_axi_awvalid,                // write address valid
  output logic s_axi_awready,                    // write address ready
  input wire logic [31:0] s_axi_wdata,           // write data
  input wire logic [3:0] s_axi_wstrb,            // write strobes
  input wire logic s_axi_wvalid,                 // write data valid
  output logic s_axi_wready,                     // write data ready
  output logic [1:0] s_axi_bresp,                // write response
  output logic s_axi_bvalid,                     // write response valid
  input wire logic s_axi_bready,                 // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr,    // read address
  input wire logic s_axi_arvalid,                // read address valid
  output logic s_axi_arready,                    // read address ready
  output logic [31:0] s_axi_rdata,               // read data
  output logic [1:0] s_axi_rresp,                // read response
  output logic s_axi_rvalid,                     // read data valid
  input wire logic s_axi_rready,                 // read data ready
  output logic ref_external,                     // external reference selected
  output logic vdd_monitor,                      // supply channel, divide by 6
  output logic voltage_mode,                     // voltage input channel selected
  output logic [OCC_W-1:0] offset_capacitance_converter_pos, // positive-input converter
  output logic [OCC_W-1:0] offset_capacitance_converter_neg  // negative-input converter
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ctrl_t ctrl;
  occ_t occ;
  logic [COEF_W-1:0] gain;
  logic [COEF_W-1:0] offset;
  logic [DATA_W-1:0] cap_in;
  logic [DATA_W-1:0] temp_in;
  logic load_pending;
  logic [ADDR_W-1:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] temp_deg;
  logic do_write;
  logic [COEF_W-1:0] next_gain;
  logic [COEF_W-1:0] next_offset;
  logic [63:0] gain_quot;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == OFS_CTRL || a == OFS_STATUS || a == OFS_GAIN || a == OFS_OFFSET || a == OFS_OCC
      || a == OFS_CAP_IN || a == OFS_RESULT || a == OFS_TEMP_IN || a == OFS_TEMP_OUT || a == OFS_OTP;
  endfunction

  cdc_scale u_scale (
    .raw(cap_in),
    .gain(gain),
    .offset(offset),
    .temp_raw(temp_in),
    .result(result),
    .temp_deg(temp_deg)
  );

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (!aw_held && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (!w_held && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(aw_addr) ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= '0;
    end else if (ctrl.mode != MODE_IDLE) begin
      ctrl.mode <= MODE_IDLE;
    end else if (do_write && aw_addr == OFS_CTRL && w_strb[0]) begin
      ctrl.mode <= w_data[CTRL_MODE_LSB +: CTRL_MODE_W];
      ctrl.extref <= w_data[CTRL_EXTREF_BIT];
      ctrl.vddmon <= w_data[CTRL_VDDMON_BIT];
      ctrl.vin <= w_data[CTRL_VIN_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      occ <= '0;
    end else if (do_write && aw_addr == OFS_OCC) begin
      occ <= (2*OCC_W)'(merge({20'h00000, occ}, w_data, w_strb));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_in <= '0;
      temp_in <= '0;
    end else if (do_write && aw_addr == OFS_CAP_IN) begin
      cap_in <= DATA_W'(merge({8'h00, cap_in}, w_data, w_strb));
    end else if (do_write && aw_addr == OFS_TEMP_IN) begin
      temp_in <= DATA_W'(merge({8'h00, temp_in}, w_data, w_strb));
    end
  end

  // ---------------------------------------------------------------
  // Coefficients
  // ---------------------------------------------------------------
  always_comb begin
    next_gain = gain;
    gain_quot = '0;
    // Gain calibration: full-scale input must map to full-scale code
    // Wide quotient so the scaled span cannot overflow; saturates instead of wrapping
    if (cap_in > MID_SCALE) begin
      gain_quot = ((64'(FULL_SCALE) - 64'(MID_SCALE)) << GAIN_FRAC) / (64'(cap_in) - 64'(MID_SCALE));
      next_gain = (gain_quot[63:COEF_W] != '0) ? '1 : gain_quot[COEF_W-1:0];
    end
    // Offset calibration: shift coefficient so zero-scale input reads mid-scale
    next_offset = COEF_W'((32'(OFFSET_DEFAULT) + (32'(cap_in) >> OFFSET_SHIFT)) - (32'(MID_SCALE) >> OFFSET_SHIFT));
  end

  // Factory gain loaded one cycle after reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_pending <= 1'b1;
    end else begin
      load_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gain <= '0;
    end else if (load_pending) begin
      gain <= otp_gain;
    end else if (ctrl.mode == MODE_GAIN_CAL) begin
      gain <= next_gain;
    end else if (do_write && aw_addr == OFS_GAIN) begin
      gain <= COEF_W'(merge({16'h0000, gain}, w_data, w_strb));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      offset <= OFFSET_DEFAULT;
    end else if (ctrl.mode == MODE_OFFS_CAL) begin
      offset <= next_offset;
    end else if (do_write && aw_addr == OFS_OFFSET) begin
      offset <= COEF_W'(merge({16'h0000, offset}, w_data, w_strb));
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
      unique case (s_axi_araddr)
        OFS_CTRL: s_axi_rdata <= 32'({ctrl.vin, ctrl.vddmon, ctrl.extref, 2'b00, ctrl.mode});
        OFS_STATUS: s_axi_rdata <= 32'({load_pending, ctrl.mode != MODE_IDLE});
        OFS_GAIN: s_axi_rdata <= 32'(gain);
        OFS_OFFSET: s_axi_rdata <= 32'(offset);
        OFS_OCC: s_axi_rdata <= 32'(occ);
        OFS_CAP_IN: s_axi_rdata <= 32'(cap_in);
        OFS_RESULT: s_axi_rdata <= 32'(ctrl.vddmon ? (cap_in / 24'(VDD_DIV)) : result);
        OFS_TEMP_IN: s_axi_rdata <= 32'(temp_in);
        OFS_TEMP_OUT: s_axi_rdata <= {{8{temp_deg[DATA_W-1]}}, temp_deg};
        OFS_OTP: s_axi_rdata <= 32'(otp_gain);
        default: s_axi_rdata <= '0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_external <= 1'b0;
      vdd_monitor <= 1'b0;
      voltage_mode <= 1'b0;
      offset_capacitance_converter_pos <= '0;
      offset_capacitance_converter_neg <= '0;
    end else begin
      ref_external <= ctrl.extref;
      vdd_monitor <= ctrl.vddmon;
      voltage_mode <= ctrl.vin;
      offset_capacitance_converter_pos <= occ.pos;
      offset_capacitance_converter_neg <= occ.neg;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Sampled reset keeps the release edge itself, still inside reset, out of the check
  AST_FACTORY_LOAD: assert property (@(posedge clk) disable iff (rst) load_pending && !rst |=> gain == $past(otp_gain))
    else $error("factory gain not loaded after reset");
  AST_GAIN_VOLATILE: assert property (@(posedge clk) $fell(rst) |=> gain == $past(otp_gain))
    else $error("gain not restored after reset");
  AST_MODE_IDLE: assert property (@(posedge clk) disable iff (rst) ctrl.mode != MODE_IDLE |=> ctrl.mode == MODE_IDLE)
    else $error("calibration mode did not return to idle");
  // Residual left after the trim must be below one offset step, so the input reads mid-scale
  AST_OFFS_CAL: assert property (@(posedge clk) disable iff (rst)
    ctrl.mode == MODE_OFFS_CAL && !do_write ##1 !do_write
    |-> int'(cap_in) - int'(MID_SCALE) - ((int'(offset) - int'(OFFSET_DEFAULT)) << OFFSET_SHIFT)
      inside {[0:(1 << OFFSET_SHIFT) - 1]})
    else $error("offset calibration wrong");
  AST_GAIN_WRITE: assert property (@(posedge clk) disable iff (rst)
    do_write && aw_addr == OFS_GAIN && w_strb == 4'hf && !load_pending && ctrl.mode != MODE_GAIN_CAL
    |=> gain == $past(w_data[COEF_W-1:0]))
    else $error("gain write lost");
  AST_OFFS_WRITE: assert property (@(posedge clk) disable iff (rst)
    do_write && aw_addr == OFS_OFFSET && w_strb == 4'hf && ctrl.mode != MODE_OFFS_CAL
    |=> offset == $past(w_data[COEF_W-1:0]))
    else $error("offset write lost");
  AST_OFFS_RESET: assert property (@(posedge clk) $fell(rst) |-> offset == OFFSET_DEFAULT)
    else $error("offset not at default after reset");
  AST_REF_SEL: assert property (@(posedge clk) disable iff (rst) ##1 ref_external == $past(ctrl.extref))
    else $error("reference select not following control");
  AST_OCC_OUT: assert property (@(posedge clk) disable iff (rst)
    ##1 {offset_capacitance_converter_pos, offset_capacitance_converter_neg} == $past(occ))
    else $error("converter setting not driven");
endmodule

// ===== pkg/cdc_cal_pkg.sv
// Package: register map, field layouts and constants of the converter calibration block
package cdc_cal_pkg;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_GAIN = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_OFFSET = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_OCC = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CAP_IN = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_TEMP_IN = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_TEMP_OUT = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_OTP = 8'h24;
  // Control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W = 2;
  localparam int CTRL_EXTREF_BIT = 4;
  localparam int CTRL_VDDMON_BIT = 5;
  localparam int CTRL_VIN_BIT = 6;
  // Mode encodings
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_GAIN_CAL = 2'h2;
  localparam logic [1:0] MODE_OFFS_CAL = 2'h3;
  // Widths and defaults
  localparam int COEF_W = 16;
  localparam int DATA_W = 24;
  localparam int OCC_W = 6;
  localparam logic [COEF_W-1:0] OFFSET_DEFAULT = 16'h8000;
  localparam logic [DATA_W-1:0] MID_SCALE = 24'h800000;
  localparam logic [DATA_W-1:0] FULL_SCALE = 24'hffffff;
  localparam int OFFSET_SHIFT = 7;   // code LSB to 31.25 aF: 2^24/2^17
  localparam int GAIN_FRAC = 15;     // gain 1.0 = 2^15
  localparam int TEMP_FRAC = 11;     // code / 2048
  localparam logic [DATA_W-1:0] TEMP_BIAS = 24'h001000;  // 4096 degrees
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam logic [COEF_W-1:0] VDD_DIV = 16'h0006;
  typedef struct packed {
    logic extref;
    logic vddmon;
    logic vin;
    logic [1:0] mode;
  } ctrl_t;
  typedef struct packed {
    logic [OCC_W-1:0] pos;
    logic [OCC_W-1:0] neg;
  } occ_t;
endpackage

// ===== src/cdc_scale.sv
// Scaling datapath: offset and gain applied to raw capacitance, temperature scaling
`timescale 1ns/1ps
module cdc_scale
  import cdc_cal_pkg::*;
(
  input wire logic [DATA_W-1:0] raw,        // raw signed-offset modulator code
  input wire logic [COEF_W-1:0] gain,       // gain coefficient
  input wire logic [COEF_W-1:0] offset,     // offset coefficient
  input wire logic [DATA_W-1:0] temp_raw,   // raw temperature code
  output logic [DATA_W-1:0] result,         // corrected capacitance code
  output logic [DATA_W-1:0] temp_deg        // whole degrees, two's complement
);
  logic signed [DATA_W+1:0] shifted;
  logic signed [DATA_W+COEF_W+2:0] prod;
  logic signed [DATA_W+COEF_W+2:0] full;
  always_comb begin
    shifted = $signed({2'b00, raw}) - $signed({2'b00, MID_SCALE})
      - ($signed({10'h000, offset}) <<< OFFSET_SHIFT)
      + ($signed({10'h000, OFFSET_DEFAULT}) <<< OFFSET_SHIFT);
    prod = shifted * $signed({1'b0, gain});
    full = (prod >>> GAIN_FRAC) + $signed({19'h00000, MID_SCALE});
    if (full < 0) begin
      result = '0;
    end else if (full > $signed({19'h00000, FULL_SCALE})) begin
      result = FULL_SCALE;
    end else begin
      result = full[DATA_W-1:0];
    end
    temp_deg = (temp_raw >> TEMP_FRAC) - TEMP_BIAS;
  end
endmodule

// ===== testbench/cdc_host_model.sv
// Host controller model: AXI4-Lite master reaching the calibration registers
`timescale 1ns/1ps
module cdc_host_model
  import cdc_cal_pkg::*;
(
  input wire logic clk,                        // clock
  output logic [ADDR_W-1:0] s_axi_awaddr,      // write address
  output logic s_axi_awvalid,                  // write address valid
  input wire logic s_axi_awready,              // write address ready
  output logic [31:0] s_axi_wdata,             // write data
  output logic [3:0] s_axi_wstrb,              // write strobes
  output logic s_axi_wvalid,                   // write data valid
  input wire logic s_axi_wready,               // write data ready
  input wire logic [1:0] s_axi_bresp,          // write response
  input wire logic s_axi_bvalid,               // write response valid
  output logic s_axi_bready,                   // write response ready
  output logic [ADDR_W-1:0] s_axi_araddr,      // read address
  output logic s_axi_arvalid,                  // read address valid
  input wire logic s_axi_arready,              // read address ready
  input wire logic [31:0] s_axi_rdata,         // read data
  input wire logic [1:0] s_axi_rresp,          // read response
  input wire logic s_axi_rvalid,               // read data valid
  output logic s_axi_rready                    // read data ready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // --------------------------------------------------------------------------
  // Bus cycles; the bench uses them to restore a kept offset copy after reset
  // and to set the converters before trimming the offset
  // --------------------------------------------------------------------------
  // Readiness is registered, so its value at the falling edge is what the
  // next rising edge samples; released lines carry the inverse value
  task automatic write(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_hit, w_hit, aw_pend, w_pend;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    while (aw_pend || w_pend) begin
      @(negedge clk);
      aw_hit = aw_pend && s_axi_awready;
      w_hit = w_pend && s_axi_wready;
      @(posedge clk);
      if (aw_hit) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
        aw_pend = 1'b0;
      end
      if (w_hit) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
        w_pend = 1'b0;
      end
    end
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ===== testbench/test_cdc_calibration_and_scaling.sv
// Self-checking bench for the calibration and scaling register block
`timescale 1ns/1ps
module test_cdc_calibration_and_scaling
  import cdc_cal_pkg::*;
;
  localparam logic [COEF_W-1:0] OTP_A = 16'h4d2c;
  localparam logic [COEF_W-1:0] OTP_B = 16'h5a5a;
  logic clk, rst;
  logic [COEF_W-1:0] otp_gain;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ref_external, vdd_monitor, voltage_mode;
  logic [OCC_W-1:0] offset_capacitance_converter_pos, offset_capacitance_converter_neg;
  int mismatches, checks, cycles;

  cdc_cal_ctrl u_cdc_cal_ctrl (.clk, .rst, .otp_gain, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ref_external, .vdd_monitor, .voltage_mode, .offset_capacitance_converter_pos,
    .offset_capacitance_converter_neg);
  cdc_host_model u_cdc_host_model (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------------------------
  // Compare and bus helpers
  // ----------------------------------------------------------------------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: response %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    u_cdc_host_model.write(a, d, resp);
    check_resp(resp, AXI_OKAY);
  endtask
  task automatic rdm(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [31:0] mask = '1);
    u_cdc_host_model.read(a, rd, resp);
    check_resp(resp, AXI_OKAY);
    check_word(rd & mask, exp);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic test_volatile();
    rdm(OFS_GAIN, {16'h0, OTP_A});
    rdm(OFS_OTP, {16'h0, OTP_A});
    rdm(OFS_STATUS, 32'h0);
    rdm(OFS_OFFSET, {16'h0, OFFSET_DEFAULT});
    wr(OFS_GAIN, 32'h1234);
    rdm(OFS_GAIN, 32'h1234);
    wr(OFS_OFFSET, 32'h8123);
    otp_gain <= OTP_B;
    do_reset();
    rdm(OFS_GAIN, {16'h0, OTP_B});
    rdm(OFS_OFFSET, {16'h0, OFFSET_DEFAULT});
    wr(OFS_OFFSET, 32'h8123);
    rdm(OFS_OFFSET, 32'h8123);
    $display("test_volatile done");
  endtask
  task automatic test_offset_cal();
    wr(OFS_OCC, 32'hfc1);
    repeat (2) @(posedge clk);
    check_word({20'h0, offset_capacitance_converter_pos, offset_capacitance_converter_neg}, 32'hfc1);
    rdm(OFS_OCC, 32'hfc1);
    wr(OFS_CAP_IN, 32'h0080_1000);
    wr(OFS_CTRL, {30'h0, MODE_OFFS_CAL});
    rdm(OFS_CTRL, {30'h0, MODE_IDLE}, 32'h3);
    rdm(OFS_OFFSET, 32'h8020);
    rdm(OFS_RESULT, {8'h0, MID_SCALE});
    $display("test_offset_cal done");
  endtask
  task automatic test_offset_write();
    wr(OFS_GAIN, 32'h8000);
    wr(OFS_OFFSET, 32'h8001);
    wr(OFS_CAP_IN, 32'h0080_0080);
    rdm(OFS_RESULT, 32'h0080_0000);
    wr(OFS_OFFSET, 32'h7fff);
    rdm(OFS_RESULT, 32'h0080_0100);
    $display("test_offset_write done");
  endtask
  task automatic test_gain_cal();
    wr(OFS_OFFSET, 32'h8000);
    wr(OFS_CAP_IN, 32'h00c0_0000);
    wr(OFS_CTRL, {30'h0, MODE_GAIN_CAL});
    rdm(OFS_CTRL, {30'h0, MODE_IDLE}, 32'h3);
    rdm(OFS_GAIN, 32'hffff);
    rdm(OFS_RESULT, 32'h00ff_ff80);
    $display("test_gain_cal done");
  endtask
  task automatic test_temp_and_ctrl();
    logic [23:0] tin[2] = '{24'h801000, 24'h7ff800};
    logic [23:0] texp[2] = '{24'h000002, 24'hffffff};
    for (int i = 0; i < 2; i++) begin
      wr(OFS_TEMP_IN, {8'h0, tin[i]});
      rdm(OFS_TEMP_OUT, {8'h0, texp[i]}, 32'hff_ffff);
    end
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CTRL, 32'h10 << i);
      repeat (2) @(posedge clk);
      check_word({29'h0, voltage_mode, vdd_monitor, ref_external}, 32'h1 << i);
    end
    wr(OFS_CTRL, 32'h20);
    wr(OFS_CAP_IN, 32'h0060_0000);
    rdm(OFS_CAP_IN, 32'h0060_0000);
    rdm(OFS_RESULT, 32'h0010_0000);
    wr(OFS_CTRL, 32'h0);
    u_cdc_host_model.read(8'h80, rd, resp);
    check_resp(resp, AXI_SLVERR);
    check_word(rd, 32'h0);
    u_cdc_host_model.write(8'h84, 32'h1, resp);
    check_resp(resp, AXI_SLVERR);
    $display("test_temp_and_ctrl done");
  endtask

  initial begin
    rst = 1'b1;
    otp_gain = OTP_A;
    mismatches = 0;
    checks = 0;
    cycles = 0;
    do_reset();
    test_volatile();
    test_offset_cal();
    test_offset_write();
    test_gain_cal();
    test_temp_and_ctrl();
    report_and_stop();
  end
endmodule
